// >>> pkg/plbk_mode_if.sv
// interface: loopback and datapath selection from control to the lanes
// assumes: driven by the top once, read by every lane alike
`timescale 1ns/10ps
`default_nettype none
interface plbk_mode_if;
   import plbk_pkg::*;
   plbk_lb_t lb;
   plbk_dp_t dp;
   modport ctl (output lb, output dp);
   modport lane (input lb, input dp);
endinterface : plbk_mode_if
`default_nettype wire

// >>> pkg/plbk_pkg.sv
// package: constants, types and decode helpers of the pma loopback block
// assumes: a single system reference clock for every user of it
package plbk_pkg;

   // ****************************************
   // widths and lanes
   // ****************************************
   localparam int unsigned PLBK_LANES = 4;
   localparam int unsigned PLBK_BLK_W = 66;
   localparam int unsigned PLBK_SD_W = 40;
   localparam int unsigned PLBK_BYP_W = 32;
   localparam int unsigned PLBK_GB_W = 132;
   localparam logic [7:0] PLBK_FILL_OUT = 8'h28;
   localparam logic [7:0] PLBK_FILL_IN = 8'h42;
   localparam logic [7:0] PLBK_FILL_ROOM = 8'h42;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [11:0] PLBK_CTRL_OFS = 12'h000;
   localparam logic [11:0] PLBK_STATUS_OFS = 12'h004;
   localparam int unsigned PLBK_CTRL_W = 5;
   localparam int unsigned PLBK_ST_W = 6;
   localparam logic [4:0] PLBK_CTRL_RST = 5'h00;
   localparam int unsigned PLBK_CTL_LOCAL = 0;
   localparam int unsigned PLBK_CTL_REMOTE = 1;
   localparam int unsigned PLBK_CTL_RSFEC = 2;
   localparam int unsigned PLBK_CTL_BYPSEL = 3;
   localparam int unsigned PLBK_CTL_W32 = 4;
   localparam int unsigned PLBK_ST_LOCAL = 0;
   localparam int unsigned PLBK_ST_REMOTE = 1;
   localparam int unsigned PLBK_ST_BYP = 2;
   localparam int unsigned PLBK_ST_CONFLICT = 3;
   localparam int unsigned PLBK_ST_LREFUSED = 4;
   localparam int unsigned PLBK_ST_BREFUSED = 5;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {PLBK_LB_NORMAL, PLBK_LB_LOCAL,
      PLBK_LB_REMOTE} plbk_lb_t;
   typedef enum logic [1:0] {PLBK_DP_RSFEC, PLBK_DP_GEARBOX,
      PLBK_DP_BYPASS} plbk_dp_t;
   typedef enum logic [1:0] {PLBK_REG_CTRL, PLBK_REG_STATUS,
      PLBK_REG_NONE} plbk_reg_t;

   function automatic plbk_reg_t plbk_decode(input logic [11:0] addr);
      plbk_reg_t r;
      r = PLBK_REG_NONE;
      if (addr == PLBK_CTRL_OFS) begin
         r = PLBK_REG_CTRL;
      end else if (addr == PLBK_STATUS_OFS) begin
         r = PLBK_REG_STATUS;
      end
      return r;
   endfunction : plbk_decode

endpackage : plbk_pkg

// >>> rtl/plbk_gearbox.sv
// gearbox: 66-bit pcs blocks to 40-bit serdes words
// assumes: flushed whenever en is low; out_data read only with out_valid
`timescale 1ns/10ps
`default_nettype none
module plbk_gearbox import plbk_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic en,
   // pcs side
   input wire logic [PLBK_BLK_W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // serdes side
   output logic [PLBK_SD_W-1:0] out_data,
   output logic out_valid
);
   typedef struct packed {
      logic [PLBK_GB_W-1:0] sh;
      logic [7:0] fill;
      logic ready;
   } plbk_gb_st_t;

   plbk_gb_st_t q, d;
   logic take;

   always_comb begin
      d = q;
      take = en & in_valid & q.ready;
      out_valid = en & (q.fill >= PLBK_FILL_OUT);
      out_data = q.sh[PLBK_SD_W-1:0];
      if (out_valid) begin
         d.sh = q.sh >> PLBK_SD_W;
         d.fill = q.fill - PLBK_FILL_OUT;
      end
      if (take) begin
         d.sh = d.sh | ({{(PLBK_GB_W-PLBK_BLK_W){1'b0}}, in_data}
            << d.fill);
         d.fill = d.fill + PLBK_FILL_IN;
      end
      if (!en) begin
         d.sh = '0;
         d.fill = 8'h00;
      end
      d.ready = !en | (d.fill <= PLBK_FILL_ROOM);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{sh: '0, fill: 8'h00, ready: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign in_ready = q.ready;

   property p_fill_bound;
      @(posedge pclk) disable iff (!presetn)
      q.fill <= 8'h84 && (q.fill >= PLBK_FILL_OUT || !out_valid);
   endproperty
   a_fill_bound: assert property (p_fill_bound)
      else $error("gearbox fill out of range");
endmodule : plbk_gearbox
`default_nettype wire

// >>> rtl/plbk_lane_mux.sv
// lane multiplexer: normal, local and remote paths of one lane
// assumes: mode identical for every lane; serdes words 40 bits
`timescale 1ns/10ps
`default_nettype none
module plbk_lane_mux import plbk_pkg::*; #(
   parameter int unsigned LANE = 0
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // mode
   plbk_mode_if.lane mode,
   // pcs transmit and gearbox
   input wire logic [PLBK_BLK_W-1:0] pcs_tx_data,
   input wire logic pcs_tx_valid,
   input wire logic [PLBK_SD_W-1:0] gb_data,
   input wire logic gb_valid,
   // serdes receive
   input wire logic [PLBK_SD_W-1:0] serdes_rx_data,
   input wire logic serdes_rx_valid,
   // outputs
   output logic [PLBK_SD_W-1:0] serdes_tx_data,
   output logic serdes_tx_valid,
   output logic [PLBK_SD_W-1:0] pcs_rx_data,
   output logic pcs_rx_valid
);
   typedef struct packed {
      logic [PLBK_SD_W-1:0] tx;
      logic txv;
      logic [PLBK_SD_W-1:0] rx;
      logic rxv;
   } plbk_lm_st_t;

   plbk_lm_st_t q, d;
   logic [PLBK_SD_W-1:0] w;
   logic wv;
   logic [PLBK_SD_W-1:0] r;

   always_comb begin
      d = q;
      w = '0;
      wv = 1'b0;
      case (mode.dp)
         PLBK_DP_RSFEC: begin
            w = pcs_tx_data[PLBK_SD_W-1:0];
            wv = pcs_tx_valid;
         end
         PLBK_DP_GEARBOX: begin
            w = gb_data;
            wv = gb_valid;
         end
         PLBK_DP_BYPASS: begin
            // only lane 0 carries data, 32 of 40 bits used
            if (LANE == 0) begin
               w = {8'h00, pcs_tx_data[PLBK_BYP_W-1:0]};
               wv = pcs_tx_valid;
            end
         end
         default: begin
            w = '0;
            wv = 1'b0;
         end
      endcase
      r = serdes_rx_data;
      if (mode.dp == PLBK_DP_BYPASS) begin
         r = (LANE == 0) ? {8'h00, serdes_rx_data[PLBK_BYP_W-1:0]} : '0;
      end
      case (mode.lb)
         PLBK_LB_LOCAL: begin
            d.tx = w;
            d.txv = wv;
            d.rx = w;
            d.rxv = wv;
         end
         PLBK_LB_REMOTE: begin
            d.tx = serdes_rx_data;
            d.txv = serdes_rx_valid;
            d.rx = r;
            d.rxv = serdes_rx_valid;
         end
         default: begin
            d.tx = w;
            d.txv = wv;
            d.rx = r;
            d.rxv = serdes_rx_valid;
         end
      endcase
      // single-lane mode: lanes above zero stay silent in every path
      if (mode.dp == PLBK_DP_BYPASS && LANE != 0) begin
         d.tx = '0;
         d.txv = 1'b0;
         d.rx = '0;
         d.rxv = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign serdes_tx_data = q.tx;
   assign serdes_tx_valid = q.txv;
   assign pcs_rx_data = q.rx;
   assign pcs_rx_valid = q.rxv;
endmodule : plbk_lane_mux
`default_nettype wire

// >>> rtl/plbk_top.sv
// top: pma loopback and low-latency path selection with apb registers
// assumes: pclk is the system reference clock of pcs and serdes words
//
// Summary of operation
// - 10G/25G no-FEC single-lane mode bypasses gearboxes
// - single-lane mode only with 32-bit serdes width
// - local: pcs transmit looped to pcs receive
// - remote: serdes receive resent on serdes transmit
// - loopbacks run entirely in reference clock domain
// - loopback applies to all lanes together
// - loopback switched only by configuration register write
// - local loopback needs RS-FEC or single-lane mode
// - plain mode: 66-bit blocks geared to 40 bits
// - plain mode receive pcs takes 40-bit words
// - single-lane loopback runs at 32/40 rate except remote serdes transmit, which resends all 40 bits
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module plbk_top import plbk_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pcs transmit
   input wire logic [PLBK_LANES-1:0][PLBK_BLK_W-1:0] pcs_tx_data,
   input wire logic [PLBK_LANES-1:0] pcs_tx_valid,
   output logic [PLBK_LANES-1:0] pcs_tx_ready,
   // pcs receive
   output logic [PLBK_LANES-1:0][PLBK_SD_W-1:0] pcs_rx_data,
   output logic [PLBK_LANES-1:0] pcs_rx_valid,
   // serdes transmit
   output logic [PLBK_LANES-1:0][PLBK_SD_W-1:0] serdes_tx_data,
   output logic [PLBK_LANES-1:0] serdes_tx_valid,
   // serdes receive
   input wire logic [PLBK_LANES-1:0][PLBK_SD_W-1:0] serdes_rx_data,
   input wire logic [PLBK_LANES-1:0] serdes_rx_valid
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [PLBK_CTRL_W-1:0] ctrl;
      plbk_lb_t lb;
      plbk_dp_t dp;
      logic [PLBK_ST_W-1:0] status;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } plbk_top_st_t;

   plbk_top_st_t q, d;
   plbk_reg_t sel_reg;
   logic setup;
   logic wr_done;
   logic want_local;
   logic want_remote;
   logic rsfec;
   logic byp_ok;
   logic local_ok;
   logic conflict;

   plbk_mode_if mode ();

   // ****************************************
   // control and apb slave
   // ****************************************
   always_comb begin
      d = q;
      sel_reg = plbk_decode(paddr);
      setup = psel & ~penable;
      wr_done = psel & penable & q.ready & pwrite;
      want_local = q.ctrl[PLBK_CTL_LOCAL];
      want_remote = q.ctrl[PLBK_CTL_REMOTE];
      rsfec = q.ctrl[PLBK_CTL_RSFEC];
      // low-latency only without fec and with 32-bit serdes width
      byp_ok = q.ctrl[PLBK_CTL_BYPSEL] & q.ctrl[PLBK_CTL_W32]
         & ~rsfec;
      conflict = want_local & want_remote;
      local_ok = want_local & ~want_remote & (rsfec | byp_ok);
      // one mode register drives every lane
      if (local_ok) begin
         d.lb = PLBK_LB_LOCAL;
      end else if (want_remote & ~want_local) begin
         d.lb = PLBK_LB_REMOTE;
      end else begin
         d.lb = PLBK_LB_NORMAL;
      end
      if (rsfec) begin
         d.dp = PLBK_DP_RSFEC;
      end else if (byp_ok) begin
         d.dp = PLBK_DP_BYPASS;
      end else begin
         d.dp = PLBK_DP_GEARBOX;
      end
      d.status = '0;
      d.status[PLBK_ST_LOCAL] = (q.lb == PLBK_LB_LOCAL);
      d.status[PLBK_ST_REMOTE] = (q.lb == PLBK_LB_REMOTE);
      d.status[PLBK_ST_BYP] = (q.dp == PLBK_DP_BYPASS);
      d.status[PLBK_ST_CONFLICT] = conflict;
      d.status[PLBK_ST_LREFUSED] = want_local & ~want_remote & ~local_ok;
      d.status[PLBK_ST_BREFUSED] = q.ctrl[PLBK_CTL_BYPSEL] & ~byp_ok;
      // setup phase prepares answer, access phase completes in one cycle
      d.ready = 1'b0;
      d.slverr = 1'b0;
      if (setup) begin
         d.ready = 1'b1;
         d.slverr = (sel_reg == PLBK_REG_NONE);
         d.rdata = '0;
         if (!pwrite) begin
            case (sel_reg)
               PLBK_REG_CTRL: begin
                  d.rdata = {{(32-PLBK_CTRL_W){1'b0}}, q.ctrl};
               end
               PLBK_REG_STATUS: begin
                  d.rdata = {{(32-PLBK_ST_W){1'b0}}, q.status};
               end
               default: begin
                  d.rdata = '0;
               end
            endcase
         end
      end
      // loopback selection only through the control register
      if (wr_done && sel_reg == PLBK_REG_CTRL) begin
         d.ctrl = pwdata[PLBK_CTRL_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{ctrl: PLBK_CTRL_RST, lb: PLBK_LB_NORMAL,
            dp: PLBK_DP_RSFEC, status: '0, rdata: '0, ready: 1'b0,
            slverr: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign prdata = q.rdata;
   assign pready = q.ready;
   assign pslverr = q.slverr;
   assign mode.lb = q.lb;
   assign mode.dp = q.dp;

   // ****************************************
   // lanes
   // ****************************************
   // every path is clocked by pclk, so looped words need no crossing
   generate
      for (genvar i = 0; i < PLBK_LANES; i++) begin : g_lane
         logic [PLBK_SD_W-1:0] gb_data;
         logic gb_valid;
         logic gb_ready;

         plbk_gearbox u_gb (
            .pclk(pclk),
            .presetn(presetn),
            .en(q.dp == PLBK_DP_GEARBOX),
            .in_data(pcs_tx_data[i]),
            .in_valid(pcs_tx_valid[i]),
            .in_ready(gb_ready),
            .out_data(gb_data),
            .out_valid(gb_valid)
         );

         plbk_lane_mux #(.LANE(i)) u_mux (
            .pclk(pclk),
            .presetn(presetn),
            .mode(mode.lane),
            .pcs_tx_data(pcs_tx_data[i]),
            .pcs_tx_valid(pcs_tx_valid[i]),
            .gb_data(gb_data),
            .gb_valid(gb_valid),
            .serdes_rx_data(serdes_rx_data[i]),
            .serdes_rx_valid(serdes_rx_valid[i]),
            .serdes_tx_data(serdes_tx_data[i]),
            .serdes_tx_valid(serdes_tx_valid[i]),
            .pcs_rx_data(pcs_rx_data[i]),
            .pcs_rx_valid(pcs_rx_valid[i])
         );

         assign pcs_tx_ready[i] = gb_ready;
      end
   endgenerate

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_bypass_entry;
      q.dp == PLBK_DP_BYPASS |->
         $past(q.ctrl[PLBK_CTL_W32]) && !$past(q.ctrl[PLBK_CTL_RSFEC])
         && $past(q.ctrl[PLBK_CTL_BYPSEL]);
   endproperty
   a_bypass_entry: assert property (p_bypass_entry)
      else $error("single-lane mode without 32-bit width");

   property p_bypass_lane0;
      q.dp == PLBK_DP_BYPASS && q.lb == PLBK_LB_NORMAL |=>
         serdes_tx_data[0][PLBK_BYP_W-1:0] ==
         $past(pcs_tx_data[0][PLBK_BYP_W-1:0])
         && serdes_tx_valid[0] == $past(pcs_tx_valid[0]);
   endproperty
   a_bypass_lane0: assert property (p_bypass_lane0)
      else $error("bypass word not passed straight through");

   property p_local_loop;
      q.lb == PLBK_LB_LOCAL |=>
         pcs_rx_data == serdes_tx_data && pcs_rx_valid == serdes_tx_valid;
   endproperty
   a_local_loop: assert property (p_local_loop)
      else $error("local loopback receive differs from transmit");

   property p_remote_loop;
      q.lb == PLBK_LB_REMOTE && q.dp != PLBK_DP_BYPASS |=>
         serdes_tx_data == $past(serdes_rx_data)
         && pcs_rx_data == $past(serdes_rx_data)
         && serdes_tx_valid == $past(serdes_rx_valid);
   endproperty
   a_remote_loop: assert property (p_remote_loop)
      else $error("remote loopback does not echo serdes receive");

   property p_mode_by_write;
      $changed(q.lb) |-> $past(wr_done, 2);
   endproperty
   a_mode_by_write: assert property (p_mode_by_write)
      else $error("loopback mode changed without a control write");

   property p_local_needs_fec;
      q.lb == PLBK_LB_LOCAL |-> q.dp != PLBK_DP_GEARBOX;
   endproperty
   a_local_needs_fec: assert property (p_local_needs_fec)
      else $error("local loopback in plain 64/66b mode");

   property p_bypass_rate;
      q.dp == PLBK_DP_BYPASS |=>
         pcs_rx_data[0][PLBK_SD_W-1:PLBK_BYP_W] == 8'h00
         && serdes_tx_valid[PLBK_LANES-1:1] == '0;
   endproperty
   a_bypass_rate: assert property (p_bypass_rate)
      else $error("bypass carries more than 32 of 40 bits");

   property p_exclusive;
      q.ctrl[PLBK_CTL_LOCAL] && q.ctrl[PLBK_CTL_REMOTE] |=>
         q.lb == PLBK_LB_NORMAL && q.status[PLBK_ST_CONFLICT];
   endproperty
   a_exclusive: assert property (p_exclusive)
      else $error("both loopbacks selected but not normal path");

   property p_apb_answer;
      psel && !penable |=> pready ##1 !pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("apb answer not one cycle after setup");

   property p_local_tx_kept;
      q.lb == PLBK_LB_LOCAL && q.dp == PLBK_DP_RSFEC |=>
         serdes_tx_data[0] == $past(pcs_tx_data[0][PLBK_SD_W-1:0])
         && serdes_tx_valid == $past(pcs_tx_valid);
   endproperty
   a_local_tx_kept: assert property (p_local_tx_kept)
      else $error("local loopback stopped serdes transmit");

   property p_local_bypass_rx;
      q.lb == PLBK_LB_LOCAL && q.dp == PLBK_DP_BYPASS |=>
         pcs_rx_data[0] ==
         {8'h00, $past(pcs_tx_data[0][PLBK_BYP_W-1:0])};
   endproperty
   a_local_bypass_rx: assert property (p_local_bypass_rx)
      else $error("single-lane local loopback word wrong");

   property p_remote_lane0;
      q.lb == PLBK_LB_REMOTE |=>
         serdes_tx_data[0] == $past(serdes_rx_data[0])
         && serdes_tx_valid[0] == $past(serdes_rx_valid[0]);
   endproperty
   a_remote_lane0: assert property (p_remote_lane0)
      else $error("remote loopback lane 0 does not echo receive");

   property p_normal_path;
      q.lb == PLBK_LB_NORMAL && q.dp == PLBK_DP_RSFEC |=>
         serdes_tx_valid == $past(pcs_tx_valid)
         && pcs_rx_data == $past(serdes_rx_data)
         && pcs_rx_valid == $past(serdes_rx_valid);
   endproperty
   a_normal_path: assert property (p_normal_path)
      else $error("normal path not used without loopback");

   property p_plain_rx_words;
      q.lb != PLBK_LB_LOCAL && q.dp == PLBK_DP_GEARBOX |=>
         pcs_rx_data == $past(serdes_rx_data);
   endproperty
   a_plain_rx_words: assert property (p_plain_rx_words)
      else $error("plain mode receive word not passed as 40 bits");

   property p_gearbox_idle;
      q.dp != PLBK_DP_GEARBOX |=> pcs_tx_ready == {PLBK_LANES{1'b1}};
   endproperty
   a_gearbox_idle: assert property (p_gearbox_idle)
      else $error("gearbox throttles outside plain mode");

   property p_ctrl_by_write;
      !(wr_done && sel_reg == PLBK_REG_CTRL) |=> $stable(q.ctrl);
   endproperty
   a_ctrl_by_write: assert property (p_ctrl_by_write)
      else $error("control register changed without a write");

   property p_local_refused;
      q.ctrl[PLBK_CTL_LOCAL] && !q.ctrl[PLBK_CTL_REMOTE]
         && !q.ctrl[PLBK_CTL_RSFEC] && !byp_ok |=>
         q.lb == PLBK_LB_NORMAL && q.status[PLBK_ST_LREFUSED];
   endproperty
   a_local_refused: assert property (p_local_refused)
      else $error("local loopback applied without fec or bypass");

   property p_bypass_refused;
      q.ctrl[PLBK_CTL_BYPSEL] && !q.ctrl[PLBK_CTL_W32] |=>
         q.dp != PLBK_DP_BYPASS && q.status[PLBK_ST_BREFUSED];
   endproperty
   a_bypass_refused: assert property (p_bypass_refused)
      else $error("single-lane mode applied without 32-bit width");

   // ****************************************
   // scenario covers
   // ****************************************
   c_local: cover property (q.lb == PLBK_LB_LOCAL && pcs_rx_valid[0]);
   c_remote: cover property (q.lb == PLBK_LB_REMOTE && serdes_tx_valid[0]);
   c_bypass_loop: cover property (q.dp == PLBK_DP_BYPASS
      && q.lb == PLBK_LB_LOCAL);
   c_gearbox: cover property (q.dp == PLBK_DP_GEARBOX
      && serdes_tx_valid[0] && !pcs_tx_ready[0]);
   c_remote_bypass: cover property (q.dp == PLBK_DP_BYPASS
      && q.lb == PLBK_LB_REMOTE && serdes_tx_valid[0]);
endmodule : plbk_top
`default_nettype wire

// >>> testbench/plbk_serdes_model.sv
// partner: far side serdes lanes, feeding receive words into the block
// assumes: shares pclk with the block; the bench orders every word
`timescale 1ns/10ps
`default_nettype none
module plbk_serdes_model import plbk_pkg::*; (
   // clock
   input wire logic pclk,
   // command from bench
   input wire logic go,
   input wire logic [PLBK_SD_W-1:0] word,
   // serdes receive
   output logic [PLBK_LANES-1:0][PLBK_SD_W-1:0] rx_data,
   output logic [PLBK_LANES-1:0] rx_valid
);
   initial begin
      rx_data = '0;
      rx_valid = '0;
   end
   // one word a cycle at the transmit rate; idle data is the previous word inverted
   always @(posedge pclk) begin
      for (int l = 0; l < PLBK_LANES; l++) begin
         rx_data[l] <= go ? word ^ PLBK_SD_W'(l) : ~rx_data[l];
      end
      rx_valid <= {PLBK_LANES{go}};
   end
endmodule : plbk_serdes_model
`default_nettype wire

// >>> testbench/plbk_top_tb.sv
// testbench: registers, loopback paths and gearbox of plbk_top
// assumes: serdes partner model; pclk 100 MHz; checks via queues
`timescale 1ns/10ps
`default_nettype none
module plbk_top_tb import plbk_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lf;
   logic [PLBK_LANES-1:0][PLBK_BLK_W-1:0] pcs_tx_data;
   logic [PLBK_LANES-1:0] pcs_tx_valid, pcs_tx_ready, pcs_rx_valid;
   logic [PLBK_LANES-1:0] serdes_tx_valid, serdes_rx_valid;
   logic [PLBK_LANES-1:0][PLBK_SD_W-1:0] pcs_rx_data, serdes_tx_data;
   logic [PLBK_LANES-1:0][PLBK_SD_W-1:0] serdes_rx_data;
   logic [PLBK_SD_W-1:0] word;
   logic [1:0] l3;
   logic [32:0] q_rd[$];
   logic [39:0] q_stx[$], q_prx[$];
   int n_mismatch, comparisons;
   localparam logic [4:0] CT[11] = '{5'h05, 5'h06, 5'h07, 5'h01, 5'h08,
      5'h0C, 5'h18, 5'h19, 5'h1A, 5'h02, 5'h04};
   localparam logic [5:0] ST[11] = '{6'h01, 6'h02, 6'h08, 6'h10, 6'h20,
      6'h20, 6'h04, 6'h05, 6'h06, 6'h02, 6'h00};

   plbk_top plbk_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pcs_tx_data(pcs_tx_data), .pcs_tx_valid(pcs_tx_valid),
      .pcs_tx_ready(pcs_tx_ready), .pcs_rx_data(pcs_rx_data),
      .pcs_rx_valid(pcs_rx_valid), .serdes_tx_data(serdes_tx_data),
      .serdes_tx_valid(serdes_tx_valid), .serdes_rx_data(serdes_rx_data),
      .serdes_rx_valid(serdes_rx_valid));
   plbk_serdes_model plbk_serdes_model_inst (.pclk(pclk), .go(go),
      .word(word), .rx_data(serdes_rx_data), .rx_valid(serdes_rx_valid));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction : rnd

   task automatic cmp(input string nm, input logic [65:0] e,
         input logic [65:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input logic [32:0] e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      if (!wr) q_rd.push_back(e);
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic stream(input logic [4:0] c, input int n);
      logic byp, loc, rem, vp, vs;
      logic [65:0] p;
      logic [39:0] s;
      byp = c[3] & c[4] & !c[2];
      loc = c[0] & !c[1] & (c[2] | byp);
      rem = c[1] & !c[0];
      l3 <= byp ? 2'h2 : 2'h1;
      repeat (n) begin
         p = 66'({rnd(), rnd(), rnd()});
         s = 40'({rnd(), rnd()});
         vp = lf[3];
         vs = lf[7];
         if (vp & !rem) q_stx.push_back(byp ? {8'h00, p[31:0]} : p[39:0]);
         if (vs & rem) q_stx.push_back(s);
         if (vp & loc) q_prx.push_back(byp ? {8'h00, p[31:0]} : p[39:0]);
         if (vs & !loc) q_prx.push_back(byp ? {8'h00, s[31:0]} : s);
         for (int l = 0; l < PLBK_LANES; l++) begin
            pcs_tx_data[l] <= p ^ PLBK_BLK_W'(l);
         end
         pcs_tx_valid <= {PLBK_LANES{vp}};
         go <= vs;
         word <= s;
         @(posedge pclk);
      end
      pcs_tx_valid <= '0;
      go <= 1'b0;
      repeat (4) @(posedge pclk);
      cmp("queues drained", 66'h0, 66'(q_stx.size() + q_prx.size()));
   endtask : stream

   task automatic gbox();
      logic [1319:0] st;
      l3 <= 2'h0;
      for (int i = 0; i < 20; i++) st[i*66 +: 66] = 66'({rnd(), rnd(),
         rnd()});
      for (int k = 0; k < 33; k++) q_stx.push_back(st[k*40 +: 40]);
      for (int i = 0; i < 20; i++) begin
         for (int l = 0; l < PLBK_LANES; l++) begin
            pcs_tx_data[l] <= st[i*66 +: 66] ^ PLBK_BLK_W'(l);
         end
         pcs_tx_valid <= '1;
         do begin
            @(posedge pclk);
         end while (pcs_tx_ready[0] !== 1'b1);
      end
      pcs_tx_valid <= '0;
      repeat (10) @(posedge pclk);
      cmp("gearbox drained", 66'h0, 66'(q_stx.size()));
   endtask : gbox

   task automatic chk_out(ref logic [39:0] q[$],
         input logic [3:0][39:0] d, input logic [3:0] v, input string nm);
      logic [39:0] e;
      e = (q.size() > 0) ? q.pop_front() : 'x;
      cmp(nm, 66'(e), 66'(d[0]));
      if (l3 == 2'h1) cmp(nm, 66'({1'b1, e ^ 40'h3}),
         66'({v[3], d[3]}));
      if (l3 == 2'h2) cmp(nm, 66'h0, 66'(v[3]));
   endtask : chk_out

   // ****************************************
   // clock, monitors, watchdog, sequence
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) begin
         cmp("apb read", 66'(q_rd.size() > 0 ? q_rd.pop_front() : 'x),
            66'({pslverr, prdata}));
      end
   end

   always @(negedge pclk) begin
      if (serdes_tx_valid[0] === 1'b1) begin
         chk_out(q_stx, serdes_tx_data, serdes_tx_valid, "serdes_tx");
      end
      if (pcs_rx_valid[0] === 1'b1) begin
         chk_out(q_prx, pcs_rx_data, pcs_rx_valid, "pcs_rx");
      end
   end

   initial begin
      #100000;
      n_mismatch++;
      wrap_up();
   end

   initial begin
      {presetn, psel, penable, pwrite, go, paddr, pwdata} = '0;
      pcs_tx_data = '0;
      pcs_tx_valid = '0;
      word = '0;
      l3 = 2'h0;
      lf = 32'hC24F;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, PLBK_CTRL_OFS, 32'h0, 33'h0);
      apb(1'b0, PLBK_STATUS_OFS, 32'h0, 33'h0);
      apb(1'b1, 12'h008, 32'hFFFF_FFFF, 33'h0);
      apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
      apb(1'b1, PLBK_STATUS_OFS, 32'hFFFF_FFFF, 33'h0);
      apb(1'b1, PLBK_CTRL_OFS, 32'hFFFF_FFE5, 33'h0);
      apb(1'b0, PLBK_CTRL_OFS, 32'h0, 33'h5);
      apb(1'b0, PLBK_STATUS_OFS, 32'h0, 33'h1);
      $display("register test done");
      for (int i = 0; i < 11; i++) begin
         apb(1'b1, PLBK_CTRL_OFS, {27'h0, CT[i]}, 33'h0);
         @(posedge pclk);
         apb(1'b0, PLBK_STATUS_OFS, 32'h0, {27'h0, ST[i]});
         if (CT[i][2] | (CT[i][3] & CT[i][4]) | (CT[i][1] & !CT[i][0]))
            stream(CT[i], 12);
      end
      $display("loopback mode test done");
      apb(1'b1, PLBK_CTRL_OFS, 32'h0, 33'h0);
      gbox();
      $display("gearbox test done");
      wrap_up();
   end
endmodule : plbk_top_tb
`default_nettype wire
